// ===== core/alarm_compare.sv
// holds the comparators that turn measurements into raw alarm conditions
// assumes: measurements and limits are stable codes in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module alarm_compare (
  input  wire logic                  pclk,       // system clock
  input  wire logic                  presetn,    // async reset, active low
  input  wire alarm_pkg::meas_t      meas,       // measured quantities
  input  wire alarm_pkg::limits_t    limits,     // programmed thresholds
  input  wire logic [23:0]           hw_version, // board hardware version
  output logic [alarm_pkg::NUM_ALARMS-1:0] cond  // raw conditions, registered
);

  logic [alarm_pkg::NUM_ALARMS-1:0] nxt_cond;
  logic [alarm_pkg::NUM_ALARMS-1:0] cond_ff;

  function automatic logic over(input logic [15:0] val, input logic [15:0] lim);
    over = (val > lim);
  endfunction

  always_comb begin
    nxt_cond = '0;
    nxt_cond[alarm_pkg::ALM_SUPPLY]      = meas.supply_mv < alarm_pkg::SUPPLY_MIN_MV;
    nxt_cond[alarm_pkg::ALM_DIODE_TEMP]  = over(meas.diode_temp, limits.diode_lim);
    nxt_cond[alarm_pkg::ALM_AVG_CURR]    = over(meas.avg_curr, limits.curr_lim)
      && (hw_version >= alarm_pkg::HW_VER_AVG_CURR_MIN);
    nxt_cond[alarm_pkg::ALM_AUX_LOOP]    = !meas.aux_closed;
    nxt_cond[alarm_pkg::ALM_AVG_POWER]   = over(meas.avg_power, limits.power_lim)
      && (hw_version <= alarm_pkg::HW_VER_AVG_POWER_MAX);
    nxt_cond[alarm_pkg::ALM_DRIVER_TEMP] = over(meas.driver_temp, limits.driver_lim);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_ff <= '0;
    end else begin
      cond_ff <= nxt_cond;
    end
  end

  assign cond = cond_ff;

endmodule
`default_nettype wire

// ===== core/laser_alarm_interlock.sv
// alarm supervision and interlock for a pulsed laser diode driver, apb register slave
// assumes: one clock pclk, presetn released once per power cycle, apb master per amba apb
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Supply alarm is raised while the board supply measures below 11 V.
// - Diode temperature alarm is raised above a programmable limit that resets to 45 degC.
// - Average current alarm is raised above the programmed average current limit.
// - Average current alarm exists only on hardware version 2.1.0 or later.
// - Auxiliary loop alarm is raised while its two contacts are open.
// - Average power alarm exists only on hardware version 2.0.0 or earlier.
// - Driver stage temperature alarm is raised above a programmable limit resetting to 70 degC.
// - Each alarm has its own mode (interlock, visible, inactive) and its own enable.
// - An interlock-mode alarm asserts the interlock output and stops emission.
// - After a trip emission stays off until reset by power cycle, whatever the condition.
// - An interlock-mode alarm also shows on its indicator so the cause is readable.
// - An inactive alarm does nothing at all.
// - Mode changes take effect only when the host commits them.
module laser_alarm_interlock #(
  parameter logic [23:0] HW_VERSION = 24'h020100   // board hardware version
) (
  input  wire logic                   pclk,        // apb clock, 50 mhz
  input  wire logic                   presetn,     // async reset, active low
  input  wire logic                   psel,        // apb select
  input  wire logic                   penable,     // apb access phase
  input  wire logic                   pwrite,      // apb direction
  input  wire logic [7:0]             paddr,       // apb byte address
  input  wire logic [31:0]            pwdata,      // apb write data
  output logic [31:0]                 prdata,      // apb read data
  output logic                        pready,      // apb ready
  output logic                        pslverr,     // apb error, unmapped address
  input  wire alarm_pkg::meas_t       meas,        // measured quantities
  output logic                        interlock,   // interlock output, high when tripped
  output logic                        emit_en,     // laser emission permit
  output logic [5:0]                  indicator,   // per-alarm indicators
  output logic                        irq          // level interrupt
);

  localparam int N = alarm_pkg::NUM_ALARMS;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [N-1:0]   status_ff, nxt_status;
  logic [N-1:0]   mask_ff, nxt_mask;
  logic [N-1:0]   enable_ff, nxt_enable;
  logic [2*N-1:0] mode_stage_ff, nxt_mode_stage;
  logic [2*N-1:0] mode_active_ff, nxt_mode_active;
  logic [N-1:0]   ind_ff, nxt_ind;
  logic [N-1:0]   trip_src_ff, nxt_trip_src;
  logic           trip_ff, nxt_trip;
  alarm_pkg::limits_t limits_ff, nxt_limits;
  logic [31:0]    prdata_ff, nxt_prdata;
  logic           pready_ff, nxt_pready;
  logic           pslverr_ff, nxt_pslverr;
  logic           irq_ff, nxt_irq;
  logic [N-1:0]   cond;

  logic           wr_acc;
  logic           rd_acc;
  logic           hit;
  logic [31:0]    rd_val;
  logic [N-1:0]   vis_hit;
  logic [N-1:0]   ilk_hit;

  function automatic alarm_pkg::alarm_mode_t mode_of(input logic [2*N-1:0] m, input int i);
    mode_of = alarm_pkg::alarm_mode_t'(m[2*i +: 2]);
  endfunction

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  alarm_compare u_cmp (
    .pclk       (pclk),
    .presetn    (presetn),
    .meas       (meas),
    .limits     (limits_ff),
    .hw_version (HW_VERSION),
    .cond       (cond)
  );

  // ----------------------------------------------------------------
  // alarm classification
  // ----------------------------------------------------------------
  always_comb begin
    vis_hit = '0;
    ilk_hit = '0;
    for (int i = 0; i < N; i++) begin
      if (cond[i] && enable_ff[i]) begin
        case (mode_of(mode_active_ff, i))
          alarm_pkg::MODE_INTERLOCK: begin
            ilk_hit[i] = 1'b1;
            vis_hit[i] = 1'b1;
          end
          alarm_pkg::MODE_VISIBLE: begin
            vis_hit[i] = 1'b1;
          end
          default: begin
            vis_hit[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // apb decode and register next state
  // ----------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite && !pready_ff;
  assign rd_acc = psel && penable && !pwrite && !pready_ff;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == alarm_pkg::OFS_STATUS) begin
      rd_val[N-1:0] = status_ff;
    end else if (paddr == alarm_pkg::OFS_MASK) begin
      rd_val[N-1:0] = mask_ff;
    end else if (paddr == alarm_pkg::OFS_MODE_STAGE) begin
      rd_val[2*N-1:0] = mode_stage_ff;
    end else if (paddr == alarm_pkg::OFS_MODE_ACTIVE) begin
      rd_val[2*N-1:0] = mode_active_ff;
    end else if (paddr == alarm_pkg::OFS_COMMIT) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == alarm_pkg::OFS_ENABLE) begin
      rd_val[N-1:0] = enable_ff;
    end else if (paddr == alarm_pkg::OFS_DIODE_LIM) begin
      rd_val[15:0] = limits_ff.diode_lim;
    end else if (paddr == alarm_pkg::OFS_DRIVER_LIM) begin
      rd_val[15:0] = limits_ff.driver_lim;
    end else if (paddr == alarm_pkg::OFS_CURR_LIM) begin
      rd_val[15:0] = limits_ff.curr_lim;
    end else if (paddr == alarm_pkg::OFS_POWER_LIM) begin
      rd_val[15:0] = limits_ff.power_lim;
    end else if (paddr == alarm_pkg::OFS_INDICATOR) begin
      rd_val[N-1:0] = ind_ff;
    end else if (paddr == alarm_pkg::OFS_TRIP) begin
      rd_val[N-1:0] = trip_src_ff;
      rd_val[31]    = trip_ff;
    end else if (paddr == alarm_pkg::OFS_HW_VERSION) begin
      rd_val[23:0] = HW_VERSION;
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    nxt_mask        = mask_ff;
    nxt_enable      = enable_ff;
    nxt_mode_stage  = mode_stage_ff;
    nxt_mode_active = mode_active_ff;
    nxt_limits      = limits_ff;
    nxt_status      = status_ff;
    nxt_pready      = psel && penable && !pready_ff;
    nxt_pslverr     = psel && penable && !pready_ff && !hit;
    nxt_prdata      = rd_acc ? rd_val : 32'h0000_0000;
    if (wr_acc) begin
      if (paddr == alarm_pkg::OFS_STATUS) begin
        nxt_status = status_ff & ~pwdata[N-1:0];
      end else if (paddr == alarm_pkg::OFS_MASK) begin
        nxt_mask = pwdata[N-1:0];
      end else if (paddr == alarm_pkg::OFS_MODE_STAGE) begin
        nxt_mode_stage = pwdata[2*N-1:0];
      end else if (paddr == alarm_pkg::OFS_COMMIT) begin
        if (pwdata[0]) begin
          nxt_mode_active = mode_stage_ff;
        end
      end else if (paddr == alarm_pkg::OFS_ENABLE) begin
        nxt_enable = pwdata[N-1:0];
      end else if (paddr == alarm_pkg::OFS_DIODE_LIM) begin
        nxt_limits.diode_lim = pwdata[15:0];
      end else if (paddr == alarm_pkg::OFS_DRIVER_LIM) begin
        nxt_limits.driver_lim = pwdata[15:0];
      end else if (paddr == alarm_pkg::OFS_CURR_LIM) begin
        nxt_limits.curr_lim = pwdata[15:0];
      end else if (paddr == alarm_pkg::OFS_POWER_LIM) begin
        nxt_limits.power_lim = pwdata[15:0];
      end
    end
    // set wins over a same-cycle write-one clear
    nxt_status = nxt_status | vis_hit;
  end

  // ----------------------------------------------------------------
  // indication, trip latch, interrupt
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ind      = vis_hit;
    nxt_trip     = trip_ff || (|ilk_hit);
    nxt_trip_src = trip_src_ff | ilk_hit;
    nxt_irq      = |(nxt_status & mask_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff      <= '0;
      mask_ff        <= alarm_pkg::MASK_RST;
      enable_ff      <= alarm_pkg::ENABLE_RST;
      mode_stage_ff  <= alarm_pkg::MODE_RST;
      mode_active_ff <= alarm_pkg::MODE_RST;
      limits_ff      <= '{diode_lim:  alarm_pkg::DIODE_LIM_RST,
                          driver_lim: alarm_pkg::DRIVER_LIM_RST,
                          curr_lim:   alarm_pkg::CURR_LIM_RST,
                          power_lim:  alarm_pkg::POWER_LIM_RST};
      ind_ff         <= '0;
      trip_src_ff    <= '0;
      trip_ff        <= 1'b0;
      prdata_ff      <= 32'h0000_0000;
      pready_ff      <= 1'b0;
      pslverr_ff     <= 1'b0;
      irq_ff         <= 1'b0;
    end else begin
      status_ff      <= nxt_status;
      mask_ff        <= nxt_mask;
      enable_ff      <= nxt_enable;
      mode_stage_ff  <= nxt_mode_stage;
      mode_active_ff <= nxt_mode_active;
      limits_ff      <= nxt_limits;
      ind_ff         <= nxt_ind;
      trip_src_ff    <= nxt_trip_src;
      trip_ff        <= nxt_trip;
      prdata_ff      <= nxt_prdata;
      pready_ff      <= nxt_pready;
      pslverr_ff     <= nxt_pslverr;
      irq_ff         <= nxt_irq;
    end
  end

  // emission permit registers the inverse of the trip latch's next state, so it drops in the same cycle as interlock
  logic emit_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emit_ff <= 1'b1;
    end else begin
      emit_ff <= !nxt_trip;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign interlock = trip_ff;
  assign emit_en   = emit_ff;
  assign indicator = ind_ff;
  assign irq       = irq_ff;

endmodule
`default_nettype wire

// ===== include/alarm_pkg.sv
// package: register map, field layout, reset values and types of the alarm interlock block
// assumes: apb slave with 32-bit data, measurements presented as unsigned fixed-point codes
`default_nettype none
package alarm_pkg;

  // alarm indices (one bit each in status, mask and enable words)
  localparam int NUM_ALARMS       = 6;
  localparam int ALM_SUPPLY       = 0;
  localparam int ALM_DIODE_TEMP   = 1;
  localparam int ALM_AVG_CURR     = 2;
  localparam int ALM_AUX_LOOP     = 3;
  localparam int ALM_AVG_POWER    = 4;
  localparam int ALM_DRIVER_TEMP  = 5;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS      = 8'h00;
  localparam logic [7:0] OFS_MASK        = 8'h04;
  localparam logic [7:0] OFS_MODE_STAGE  = 8'h08;
  localparam logic [7:0] OFS_MODE_ACTIVE = 8'h0c;
  localparam logic [7:0] OFS_COMMIT      = 8'h10;
  localparam logic [7:0] OFS_ENABLE      = 8'h14;
  localparam logic [7:0] OFS_DIODE_LIM   = 8'h18;
  localparam logic [7:0] OFS_DRIVER_LIM  = 8'h1c;
  localparam logic [7:0] OFS_CURR_LIM    = 8'h20;
  localparam logic [7:0] OFS_POWER_LIM   = 8'h24;
  localparam logic [7:0] OFS_INDICATOR   = 8'h28;
  localparam logic [7:0] OFS_TRIP        = 8'h2c;
  localparam logic [7:0] OFS_HW_VERSION  = 8'h30;

  // measurement codes: voltage in mV, temperature in 0.1 degC, current in mA, power in mW
  localparam int MEAS_W = 16;
  localparam logic [15:0] SUPPLY_MIN_MV    = 16'h2af8;  // 11 V
  localparam logic [15:0] DIODE_LIM_RST    = 16'h01c2;  // 45.0 degC
  localparam logic [15:0] DRIVER_LIM_RST   = 16'h02bc;  // 70.0 degC
  localparam logic [15:0] CURR_LIM_RST     = 16'hffff;
  localparam logic [15:0] POWER_LIM_RST    = 16'hffff;
  localparam logic [5:0]  ENABLE_RST       = 6'h3f;
  localparam logic [5:0]  MASK_RST         = 6'h00;

  // hardware version thresholds, packed major.minor.patch as 8 bits each
  localparam logic [23:0] HW_VER_AVG_CURR_MIN  = 24'h020100;  // 2.1.0
  localparam logic [23:0] HW_VER_AVG_POWER_MAX = 24'h020000;  // 2.0.0

  typedef enum logic [1:0] {
    MODE_INACTIVE  = 2'h0,
    MODE_VISIBLE   = 2'h1,
    MODE_INTERLOCK = 2'h2
  } alarm_mode_t;

  localparam logic [11:0] MODE_RST = 12'h555;  // every alarm visible

  typedef struct packed {
    logic [15:0] supply_mv;
    logic [15:0] diode_temp;
    logic [15:0] avg_curr;
    logic [15:0] avg_power;
    logic [15:0] driver_temp;
    logic        aux_closed;
  } meas_t;

  typedef struct packed {
    logic [15:0] diode_lim;
    logic [15:0] driver_lim;
    logic [15:0] curr_lim;
    logic [15:0] power_lim;
  } limits_t;

endpackage
`default_nettype wire

// ===== sim/alarm_checker.sv
// checker for the alarm interlock block, bound to its top module
// assumes: single clock pclk, presetn async active low
`timescale 1ns/1ps
`default_nettype none
module alarm_checker #(
  parameter logic [23:0] HW_VERSION = 24'h020100  // board hardware version
) (
  input wire logic        pclk,       // clock
  input wire logic        presetn,    // reset, active low
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb access phase
  input wire logic        pwrite,     // apb direction
  input wire logic [7:0]  paddr,      // apb address
  input wire logic [31:0] pwdata,     // apb write data
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire alarm_pkg::meas_t meas,  // measurements
  input wire logic        interlock,  // interlock output
  input wire logic        emit_en,    // emission permit
  input wire logic [5:0]  indicator,  // alarm indicators
  input wire logic        irq         // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  interlock_hold_a: assert property (interlock |=> interlock)
    else $error("interlock dropped before reset");
  emit_stays_a: assert property (!emit_en |=> !emit_en)
    else $error("emission restored before reset");
  emit_gate_a: assert property (emit_en == !interlock)
    else $error("emission permit disagrees with interlock");
  trip_cause_a: assert property ($rose(interlock) |-> indicator != 6'h00)
    else $error("trip without indicated cause");
  no_power_a: assert property ((HW_VERSION > 24'h020000) |-> !indicator[4])
    else $error("average power alarm on newer hardware");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not given one cycle after access");
  slverr_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready cycle");
endmodule
bind laser_alarm_interlock alarm_checker #(.HW_VERSION(HW_VERSION)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .interlock(interlock), .emit_en(emit_en), .indicator(indicator), .irq(irq));
`default_nettype wire

// ===== sim/meas_source.sv
// measurement sources and auxiliary contact loop seen by the alarm block
// assumes: faults are requested by the bench one bit per alarm index
`timescale 1ns/1ps
`default_nettype none
module meas_source (
  input  wire logic        pclk,   // system clock
  input  wire logic [5:0]  fault,  // per-alarm fault request
  output var alarm_pkg::meas_t meas // measured levels
);
  // nominal values sit exactly on each threshold, faults one code past it
  always_ff @(posedge pclk) begin
    meas.supply_mv   <= fault[0] ? 16'h2af7 : 16'h2af8;
    meas.diode_temp  <= fault[1] ? 16'h01c3 : 16'h01c2;
    meas.avg_curr    <= fault[2] ? 16'h0101 : 16'h0100;
    meas.aux_closed  <= !fault[3];
    meas.avg_power   <= fault[4] ? 16'h0101 : 16'h0100;
    meas.driver_temp <= fault[5] ? 16'h02bd : 16'h02bc;
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the alarm interlock block
// assumes: meas_source partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, interlock, emit_en, irq, err;
  logic [5:0] indicator, fault = 6'h00;
  alarm_pkg::meas_t meas;
  int bad_count = 0, checks = 0, cyc = 0;

  always #10 pclk = ~pclk;
  meas_source src (.pclk(pclk), .fault(fault), .meas(meas));
  laser_alarm_interlock #(.HW_VERSION(24'h020100)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .interlock(interlock), .emit_en(emit_en), .indicator(indicator), .irq(irq));

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is taken as sampled at each rising edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  // fault change lands in cond two edges later, outputs one more
  task automatic set_fault(input logic [5:0] f);
    @(posedge pclk);
    fault <= f;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic outs(input logic [5:0] ind, input logic lock);
    check("indicator", {26'h0, indicator}, {26'h0, ind});
    check("interlock", {31'h0, interlock}, {31'h0, lock});
    check("emit_en", {31'h0, emit_en}, {31'h0, !lock});
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs;
    rd_chk("mask", alarm_pkg::OFS_MASK, 32'h0);
    rd_chk("mode", alarm_pkg::OFS_MODE_ACTIVE, 32'h555);
    rd_chk("enable", alarm_pkg::OFS_ENABLE, 32'h3f);
    rd_chk("diode_lim", alarm_pkg::OFS_DIODE_LIM, 32'h1c2);
    rd_chk("driver_lim", alarm_pkg::OFS_DRIVER_LIM, 32'h2bc);
    rd_chk("hw", alarm_pkg::OFS_HW_VERSION, 32'h20100);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
  endtask
  task automatic t_alarms;
    apb(1'b1, alarm_pkg::OFS_CURR_LIM, 32'h100);
    apb(1'b1, alarm_pkg::OFS_POWER_LIM, 32'h100);
    for (int i = 0; i < 6; i++) begin
      set_fault(6'h01 << i);
      check("ind_each", {26'h0, indicator}, (i == 4) ? 32'h0 : (32'h1 << i));
      outs((i == 4) ? 6'h00 : (6'h01 << i), 1'b0);
    end
    set_fault(6'h00);
    outs(6'h00, 1'b0);
    rd_chk("status", alarm_pkg::OFS_STATUS, 32'h2f);
    apb(1'b1, alarm_pkg::OFS_STATUS, 32'h3f);
    rd_chk("status_clr", alarm_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic t_irq;
    apb(1'b1, alarm_pkg::OFS_MASK, 32'h1);
    set_fault(6'h01);
    set_fault(6'h00);
    check("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b1, alarm_pkg::OFS_STATUS, 32'h1);
    @(negedge pclk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, alarm_pkg::OFS_MASK, 32'h0);
  endtask
  task automatic t_modes;
    apb(1'b1, alarm_pkg::OFS_MODE_STAGE, 32'h554);
    set_fault(6'h01);
    outs(6'h01, 1'b0);
    rd_chk("active_old", alarm_pkg::OFS_MODE_ACTIVE, 32'h555);
    set_fault(6'h00);
    apb(1'b1, alarm_pkg::OFS_COMMIT, 32'h1);
    rd_chk("active_new", alarm_pkg::OFS_MODE_ACTIVE, 32'h554);
    apb(1'b1, alarm_pkg::OFS_STATUS, 32'h3f);
    apb(1'b1, alarm_pkg::OFS_ENABLE, 32'h3d);
    set_fault(6'h03);
    outs(6'h00, 1'b0);
    rd_chk("status_quiet", alarm_pkg::OFS_STATUS, 32'h0);
    set_fault(6'h00);
    apb(1'b1, alarm_pkg::OFS_ENABLE, 32'h3f);
  endtask
  task automatic t_trip;
    apb(1'b1, alarm_pkg::OFS_MODE_STAGE, 32'h595);
    apb(1'b1, alarm_pkg::OFS_COMMIT, 32'h1);
    set_fault(6'h08);
    outs(6'h08, 1'b1);
    rd_chk("trip", alarm_pkg::OFS_TRIP, 32'h80000008);
    set_fault(6'h00);
    outs(6'h00, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    outs(6'h00, 1'b0);
  endtask

  // ------------------------------
  // run control
  // ------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_alarms();
    t_irq();
    t_modes();
    t_trip();
    print_verdict();
  end
endmodule
`default_nettype wire
